// ===== hw/e1rs_monitor.sv
// E1 receive status monitor: slip, phase and alarm status registers
// How it works
// - Slip toggle flips on every controlled slip.
// - Slip direction one repeated, zero lost.
// - Alternating pattern flag after 512 bits with at most one error.
// - Double FAS error when both last errored.
// - Phase frame flag is phase word top.
// - Five-bit slot count split across registers.
// - Three-bit whole bit count, low bits 5-3.
// - Eighth-bit count, valid at 4.096 MHz only.
// - Submultiframe one CRC result in bit 7.
// - Submultiframe two CRC result in bit 6.
// - Remote failure after five bad E-bit seconds.
// - Loss after 255 bit positions without pulse.
// - Loss ends at 12.5% ones over 255.
// - Channel 16 all ones, updated per frame.
// - All-ones alarm, criteria picked by control bit.
// - Remote alarm state updated per NFAS frame.
// - RAI plus CRC bit updated per submultiframe.
// - Sync lost input high while alignment lost.
// - Remote alarm bit is NFAS bit three.
// - RAI and E-bit zero evaluated per multiframe.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module e1rs_monitor
  import e1rs_pkg::*;
(
  // Clock and reset
  input  wire logic           ref_clk_i,
  input  wire logic           arst_n_i,
  // Register port
  input  wire e1rs_bus_req_t  bus_i,
  output logic [7:0]          rd_data_o,
  // Pins from the line side
  input  wire logic           sys_frame_pulse_i,
  input  wire logic           extracted_8k_output_i,
  // Receive framer events, same clock
  input  wire e1rs_rx_bit_t   rx_bit_i,
  input  wire e1rs_frame_ev_t frame_ev_i,
  input  wire logic           subbit_tick_i,
  input  wire logic           slip_event_i,
  input  wire logic           slip_repeat_i,
  input  wire logic           frame_sync_lost_i,
  input  wire logic           ebit_error_i,
  input  wire logic           one_sec_tick_i
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic        fp_s1;
    logic        fp_s2;
    logic        fp_s3;
    logic        e8_s1;
    logic        e8_s2;
    logic        e8_s3;
    logic [11:0] ph_cnt;
    logic [11:0] ph_word;
    logic        slip_toggle;
    logic        slip_direction;
    logic [8:0]  win_cnt;
    logic [9:0]  win_err;
    logic [9:0]  win_zeros;
    logic        last_bit;
    logic        alt_pattern_detect;
    logic        ais_prev_ok;
    logic        all_ones_alarm;
    logic [1:0]  fas_hist;
    logic        double_fas_error;
    logic        submf1_check_error;
    logic        submf2_check_error;
    logic [9:0]  ebit_cnt;
    logic        sec_bad;
    logic [2:0]  good_secs;
    logic        remote_checker_failure;
    logic [7:0]  zero_run;
    logic        los_act;
    logic [7:0]  los_cnt;
    logic [7:0]  los_ones;
    logic        loss;
    logic        ts16_all_ones;
    logic        remote_alarm_state;
    logic        mf_cond;
    logic        rai_crc_condition;
    logic        alarm_criteria_select;
    logic [7:0]  rd_data;
  } e1rs_state_t;

  e1rs_state_t s_reg;
  e1rs_state_t s_next;

  function automatic logic [9:0] e1rs_inc10(input logic [9:0] v);
    e1rs_inc10 = (v == 10'h3ff) ? v : v + 10'h001;
  endfunction

  function automatic logic [7:0] e1rs_inc8(input logic [7:0] v);
    e1rs_inc8 = (v == 8'hff) ? v : v + 8'h01;
  endfunction

  // ==========================================================================
  // Derived terms
  logic       fp_rise;
  logic       e8_rise;
  logic       alt_err;
  logic [9:0] err_now;
  logic [9:0] zeros_now;
  logic       ais_ok;
  logic [7:0] ones_now;
  logic [9:0] ebit_now;
  logic       bad_now;
  logic       sec_ok;
  logic [7:0] hi_word;
  logic [7:0] lo_word;
  logic [7:0] alarm_word;

  assign fp_rise   = s_reg.fp_s2 & ~s_reg.fp_s3;
  assign e8_rise   = s_reg.e8_s2 & ~s_reg.e8_s3;
  assign alt_err   = rx_bit_i.data == s_reg.last_bit;
  assign err_now   = alt_err ? e1rs_inc10(s_reg.win_err) : s_reg.win_err;
  assign zeros_now = rx_bit_i.data ? s_reg.win_zeros : e1rs_inc10(s_reg.win_zeros);
  assign ais_ok    = zeros_now < AIS_MAX_ZEROS;
  assign ones_now  = rx_bit_i.pulse ? e1rs_inc8(s_reg.los_ones) : s_reg.los_ones;
  assign ebit_now  = ebit_error_i ? e1rs_inc10(s_reg.ebit_cnt) : s_reg.ebit_cnt;
  // A remote alarm bit or alignment loss in the second spoils it
  assign bad_now   = s_reg.sec_bad | frame_sync_lost_i
                   | (frame_ev_i.nfas_valid & frame_ev_i.remote_alarm_bit);
  assign sec_ok    = (ebit_now > EBIT_LIMIT) & ~bad_now;

  assign hi_word    = {s_reg.slip_toggle, s_reg.slip_direction,
                       s_reg.alt_pattern_detect, s_reg.double_fas_error,
                       s_reg.ph_word[11:8]};
  assign lo_word    = s_reg.ph_word[7:0];
  assign alarm_word = {s_reg.submf1_check_error, s_reg.submf2_check_error,
                       s_reg.remote_checker_failure, s_reg.loss,
                       s_reg.ts16_all_ones, s_reg.all_ones_alarm,
                       s_reg.remote_alarm_state, s_reg.rai_crc_condition};

  // ==========================================================================
  // Next state
  always_comb begin
    s_next = s_reg;

    // Pins pass two flops before any logic looks at them
    s_next.fp_s1 = sys_frame_pulse_i;
    s_next.fp_s2 = s_reg.fp_s1;
    s_next.fp_s3 = s_reg.fp_s2;
    s_next.e8_s1 = extracted_8k_output_i;
    s_next.e8_s2 = s_reg.e8_s1;
    s_next.e8_s3 = s_reg.e8_s2;

    // Phase counter in eighth-bit steps: {frame, slot[4:0], bit[2:0], eighth[2:0]}
    if (e8_rise) begin
      s_next.ph_word = s_reg.ph_cnt;
    end
    if (fp_rise) begin
      s_next.ph_cnt = '0;
    end else if (subbit_tick_i && s_reg.ph_cnt != PH_MAX) begin
      s_next.ph_cnt = s_reg.ph_cnt + 12'h001;
    end

    if (slip_event_i) begin
      s_next.slip_toggle    = ~s_reg.slip_toggle;
      s_next.slip_direction = slip_repeat_i;
    end

    // One shared 512-bit window for pattern and all-ones detection
    if (rx_bit_i.strobe) begin
      s_next.last_bit = rx_bit_i.data;
      if (err_now > AUX_MAX_ERR) begin
        s_next.alt_pattern_detect = 1'b0;
      end
      if (s_reg.win_cnt == WIN_LAST) begin
        s_next.win_cnt            = '0;
        s_next.win_err            = '0;
        s_next.win_zeros          = '0;
        s_next.alt_pattern_detect = err_now <= AUX_MAX_ERR;
        s_next.ais_prev_ok        = ais_ok;
        // Strict criteria want two clean windows in a row
        s_next.all_ones_alarm     = s_reg.alarm_criteria_select ?
                                    (ais_ok & s_reg.ais_prev_ok) : ais_ok;
      end else begin
        s_next.win_cnt   = s_reg.win_cnt + 9'h001;
        s_next.win_err   = err_now;
        s_next.win_zeros = zeros_now;
      end
    end

    // Loss of signal
    if (rx_bit_i.strobe) begin
      if (rx_bit_i.pulse) begin
        s_next.zero_run = '0;
      end else begin
        s_next.zero_run = e1rs_inc8(s_reg.zero_run);
      end
      if (!s_reg.loss) begin
        s_next.los_act = 1'b0;
        if (!rx_bit_i.pulse && s_reg.zero_run == LOS_ZERO_RUN - 8'h01) begin
          s_next.loss = 1'b1;
        end
      end else if (!s_reg.los_act) begin
        // Recovery window opens only on a pulse
        if (rx_bit_i.pulse) begin
          s_next.los_act  = 1'b1;
          s_next.los_cnt  = 8'h01;
          s_next.los_ones = 8'h01;
        end
      end else begin
        s_next.los_cnt  = s_reg.los_cnt + 8'h01;
        s_next.los_ones = ones_now;
        if (s_reg.los_cnt == LOS_WIN - 8'h01) begin
          s_next.los_act = 1'b0;
          if (ones_now >= LOS_MIN_ONES) begin
            s_next.loss = 1'b0;
          end
        end
      end
    end

    if (frame_ev_i.fas_valid) begin
      s_next.fas_hist         = {s_reg.fas_hist[0], frame_ev_i.fas_errored};
      s_next.double_fas_error = frame_ev_i.fas_errored & s_reg.fas_hist[0];
    end

    if (frame_ev_i.frame_end) begin
      s_next.ts16_all_ones = frame_ev_i.ts16_byte == TS16_ALL_ONES;
    end

    if (frame_ev_i.nfas_valid) begin
      s_next.remote_alarm_state = frame_ev_i.remote_alarm_bit;
    end

    if (frame_ev_i.mf_end) begin
      s_next.mf_cond = s_reg.remote_alarm_state &
                       (frame_ev_i.e_bits != E_BITS_CLEAN);
    end

    if (frame_ev_i.smf_end) begin
      if (frame_ev_i.smf_two) begin
        s_next.submf2_check_error = frame_ev_i.crc_error;
      end else begin
        s_next.submf1_check_error = frame_ev_i.crc_error;
      end
      s_next.rai_crc_condition = s_reg.mf_cond;
    end

    // Remote checker failure, judged once a second
    s_next.ebit_cnt = ebit_now;
    s_next.sec_bad  = bad_now;
    if (one_sec_tick_i) begin
      s_next.ebit_cnt = '0;
      s_next.sec_bad  = 1'b0;
      if (!sec_ok) begin
        s_next.good_secs = '0;
      end else if (s_reg.good_secs != REMOTE_CHECKER_FAILURE_SECONDS) begin
        s_next.good_secs = s_reg.good_secs + 3'h1;
      end
      s_next.remote_checker_failure =
        sec_ok && (s_reg.good_secs >= REMOTE_CHECKER_FAILURE_SECONDS - 3'h1);
    end

    // Register port; only the control register takes writes
    if (bus_i.wr && bus_i.addr == ADDR_CTRL) begin
      s_next.alarm_criteria_select = bus_i.wdata[CTRL_SEL_BIT];
    end
    s_next.rd_data = '0;
    if (bus_i.rd) begin
      case (bus_i.addr)
        ADDR_SLIP_PHASE_HI: s_next.rd_data = hi_word;
        ADDR_PHASE_LO:      s_next.rd_data = lo_word;
        ADDR_ALARM_ONE:     s_next.rd_data = alarm_word;
        ADDR_CTRL:          s_next.rd_data = {7'h00, s_reg.alarm_criteria_select};
        default:            s_next.rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_data_o = s_reg.rd_data;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  a_slip_toggle_flip: assert property (
    slip_event_i |=> s_reg.slip_toggle != $past(s_reg.slip_toggle))
    else $error("slip toggle did not flip");

  a_slip_dir_set: assert property (
    slip_event_i |=> s_reg.slip_direction == $past(slip_repeat_i))
    else $error("slip direction wrong");

  a_aux_window_end: assert property (
    $rose(s_reg.alt_pattern_detect) |-> $past(s_reg.win_cnt) == WIN_LAST)
    else $error("pattern flag rose outside window end");

  a_double_fas_pair: assert property (
    (frame_ev_i.fas_valid && frame_ev_i.fas_errored && s_reg.fas_hist[0])
      |=> s_reg.double_fas_error)
    else $error("double fas error missed");

  a_phase_capture: assert property (
    e8_rise |=> s_reg.ph_word == $past(s_reg.ph_cnt))
    else $error("phase word not captured");

  a_phase_hi_read: assert property (
    (bus_i.rd && bus_i.addr == ADDR_SLIP_PHASE_HI) |=> rd_data_o[3] == $past(s_reg.ph_word[11]))
    else $error("phase frame flag misplaced");

  a_crc_smf1_result: assert property (
    (frame_ev_i.smf_end && !frame_ev_i.smf_two)
      |=> s_reg.submf1_check_error == $past(frame_ev_i.crc_error))
    else $error("submultiframe one result wrong");

  a_crc_smf2_result: assert property (
    (frame_ev_i.smf_end && frame_ev_i.smf_two)
      |=> s_reg.submf2_check_error == $past(frame_ev_i.crc_error))
    else $error("submultiframe two result wrong");

  a_los_declare: assert property (
    (!s_reg.loss && rx_bit_i.strobe && !rx_bit_i.pulse && s_reg.zero_run == 8'hfe)
      |=> s_reg.loss)
    else $error("loss of signal not declared");

  a_remote_checker_failure_needs_secs: assert property (
    $rose(s_reg.remote_checker_failure) |-> $past(s_reg.good_secs) >= 3'h4)
    else $error("remote failure too early");

  a_remote_alarm_state_follows: assert property (
    frame_ev_i.nfas_valid |=> s_reg.remote_alarm_state == $past(frame_ev_i.remote_alarm_bit))
    else $error("remote alarm state not updated");

  a_status_read_only: assert property (
    (bus_i.wr && bus_i.addr != ADDR_CTRL) |=> $stable(s_reg.alarm_criteria_select))
    else $error("status write had an effect");

  c_slip_seen: cover property (slip_event_i ##1 s_reg.slip_toggle);
  c_aux_seen: cover property ($rose(s_reg.alt_pattern_detect));
  c_loss_cycle: cover property ($fell(s_reg.loss));
  c_remote_checker_failure_seen: cover property ($rose(s_reg.remote_checker_failure));

endmodule // e1rs_monitor

`default_nettype wire

// ===== hw/e1rs_pkg.sv
// Package: register map, field layout, counts and carriers of the E1 receive status monitor
package e1rs_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_SLIP_PHASE_HI = 8'h15;
  localparam logic [7:0] ADDR_PHASE_LO      = 8'h16;
  localparam logic [7:0] ADDR_ALARM_ONE     = 8'h19;
  localparam logic [7:0] ADDR_CTRL          = 8'h1a;
  localparam int         CTRL_SEL_BIT       = 0;

  // ==========================================================================
  // Counts
  localparam logic [8:0]  WIN_LAST       = 9'h1ff;   // 512-bit window
  localparam logic [9:0]  AUX_MAX_ERR    = 10'h001;  // about 1e-3 of 512
  localparam logic [9:0]  AIS_MAX_ZEROS  = 10'h003;
  localparam logic [7:0]  LOS_ZERO_RUN   = 8'hff;    // 255 bit positions
  localparam logic [7:0]  LOS_WIN        = 8'hff;    // 255 bit positions
  localparam logic [7:0]  LOS_MIN_ONES   = 8'h20;    // 12.5% of 255, rounded up
  localparam logic [9:0]  EBIT_LIMIT     = 10'h3dd;  // 989
  localparam logic [2:0]  REMOTE_CHECKER_FAILURE_SECONDS  = 3'h5;
  localparam logic [11:0] PH_MAX         = 12'hfff;
  localparam logic [7:0]  TS16_ALL_ONES  = 8'hff;
  localparam logic [1:0]  E_BITS_CLEAN   = 2'h3;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } e1rs_bus_req_t;

  typedef struct packed {
    logic strobe;  // one cycle per received bit position
    logic data;    // decoded bit value
    logic pulse;   // a line pulse was present in this position
  } e1rs_rx_bit_t;

  typedef struct packed {
    logic       fas_valid;
    logic       fas_errored;
    logic       nfas_valid;
    logic       remote_alarm_bit;
    logic       frame_end;
    logic [7:0] ts16_byte;
    logic       smf_end;
    logic       smf_two;
    logic       crc_error;
    logic       mf_end;
    logic [1:0] e_bits;
  } e1rs_frame_ev_t;

endpackage : e1rs_pkg

// ===== test/e1rs_line_model.sv
// Line-side model: bit positions that are silent, alternating or all ones
`timescale 1ns/1ps
`default_nettype none

module e1rs_line_model
  import e1rs_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       arst_n_i,
  // Content: 0 silent, 1 alternating, 2 all ones
  input  wire logic [1:0] mode_i,
  // Received bit positions
  output var e1rs_rx_bit_t rx_bit_o
);
  logic [1:0] div_reg;
  logic       alt_reg;
  logic       bit_val;

  assign bit_val = (mode_i == 2'h2) || ((mode_i == 2'h1) && alt_reg);

  // ==========================================================================
  // One bit position every four clocks
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_reg  <= 2'h0;
      alt_reg  <= 1'b0;
      rx_bit_o <= '0;
    end else begin
      div_reg         <= div_reg + 2'h1;
      rx_bit_o.strobe <= (div_reg == 2'h3);
      if (div_reg == 2'h3) begin
        alt_reg        <= ~alt_reg;
        rx_bit_o.data  <= bit_val;
        rx_bit_o.pulse <= bit_val;
      end else begin
        // Churn between strobes so stale content is never trusted
        rx_bit_o.data  <= ~rx_bit_o.data;
        rx_bit_o.pulse <= ~rx_bit_o.pulse;
      end
    end
  end
endmodule // e1rs_line_model

`default_nettype wire

// ===== test/e1rs_monitor_bench.sv
// Self-checking bench of the receive status monitor
`timescale 1ns/1ps
`default_nettype none

module e1rs_monitor_bench;
  import e1rs_pkg::*;

  logic           ref_clk;
  logic           arst_n;
  e1rs_bus_req_t  bus;
  logic [7:0]     rd_data;
  logic           sys_fp;
  logic           ext_8k;
  e1rs_rx_bit_t   rx_bit;
  e1rs_frame_ev_t frame_ev;
  logic           subbit_tick;
  logic           slip_event;
  logic           slip_repeat;
  logic           sync_lost;
  logic           ebit_error;
  logic           sec_tick;
  logic [1:0]     line_mode;
  logic [15:0]    exp_q[$];
  logic [15:0]    note;
  logic           rd_q;
  int             bad_count;
  int             n_compared;
  int             cycles;
  int             seed;
  int             rnd;

  e1rs_monitor e1rs_monitor_i (
    .ref_clk_i(ref_clk), .arst_n_i(arst_n), .bus_i(bus), .rd_data_o(rd_data),
    .sys_frame_pulse_i(sys_fp), .extracted_8k_output_i(ext_8k), .rx_bit_i(rx_bit),
    .frame_ev_i(frame_ev), .subbit_tick_i(subbit_tick), .slip_event_i(slip_event),
    .slip_repeat_i(slip_repeat), .frame_sync_lost_i(sync_lost),
    .ebit_error_i(ebit_error), .one_sec_tick_i(sec_tick));

  e1rs_line_model e1rs_line_model_i (
    .ref_clk_i(ref_clk), .arst_n_i(arst_n), .mode_i(line_mode), .rx_bit_o(rx_bit));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ==========================================================================
  // Shared tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    n_compared++;
    if (seen !== expv) begin
      bad_count++;
      $display("wrong value at %0t: read %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    exp_q.push_back({e, m});
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge ref_clk);
    bus.wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Kind 0 FAS, 1 NFAS, 2 frame end, 3 submultiframe end, 4 multiframe end
  task automatic ev(input int kind, input logic a, input logic [7:0] b);
    e1rs_frame_ev_t v;
    v = '0;
    case (kind)
      0: begin v.fas_valid = 1'b1; v.fas_errored = a; end
      1: begin v.nfas_valid = 1'b1; v.remote_alarm_bit = a; end
      2: begin v.frame_end = 1'b1; v.ts16_byte = b; end
      4: begin v.mf_end = 1'b1; v.e_bits = b[1:0]; end
      default: begin v.smf_end = 1'b1; v.smf_two = b[0]; v.crc_error = a; end
    endcase
    frame_ev <= v;
    @(posedge ref_clk);
    frame_ev <= '0;
    @(posedge ref_clk);
  endtask

  task automatic slips(input int n, input logic [3:0] dirs);
    slip_event <= 1'b1;
    for (int i = 0; i < n; i++) begin
      slip_repeat <= dirs[i];
      @(posedge ref_clk);
    end
    slip_event <= 1'b0;
    @(posedge ref_clk);
  endtask

  // One second of n clocks, closed by a one-cycle tick
  task automatic sec(input int n);
    repeat (n) @(posedge ref_clk);
    sec_tick <= 1'b1;
    @(posedge ref_clk);
    sec_tick <= 1'b0;
  endtask

  // ==========================================================================
  // Watcher: read data stand only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rd_q) begin
      note = exp_q.pop_front();
      check(rd_data & note[7:0], note[15:8]);
    end
    rd_q <= bus.rd;
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      final_report();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    seed = 78770;
    bad_count = 0;
    n_compared = 0;
    cycles = 0;
    rd_q = 1'b0;
    arst_n = 1'b0;
    bus = '0;
    sys_fp = 1'b0;
    ext_8k = 1'b0;
    frame_ev = '0;
    subbit_tick = 1'b0;
    slip_event = 1'b0;
    slip_repeat = 1'b0;
    sync_lost = 1'b0;
    ebit_error = 1'b0;
    sec_tick = 1'b0;
    line_mode = 2'h0;
    cyc(6);
    arst_n <= 1'b1;
    cyc(1);
    rd(ADDR_SLIP_PHASE_HI, 8'h00, 8'hff);
    rd(ADDR_ALARM_ONE, 8'h00, 8'hff);
    rd(8'h00, 8'h00, 8'hff);
    slips(1, 4'h1);
    rd(ADDR_SLIP_PHASE_HI, 8'hc0, 8'hc0);
    slips(1, 4'h0);
    rd(ADDR_SLIP_PHASE_HI, 8'h00, 8'hc0);
    slips(2, 4'h2);
    rd(ADDR_SLIP_PHASE_HI, 8'h40, 8'hc0);
    ev(0, 1'b1, 8'h00);
    rd(ADDR_SLIP_PHASE_HI, 8'h00, 8'h10);
    ev(0, 1'b1, 8'h00);
    rd(ADDR_SLIP_PHASE_HI, 8'h10, 8'h10);
    ev(0, 1'b0, 8'h00);
    rd(ADDR_SLIP_PHASE_HI, 8'h00, 8'h10);
    ev(3, 1'b1, 8'h00);
    ev(3, 1'b0, 8'h01);
    rd(ADDR_ALARM_ONE, 8'h80, 8'hc0);
    ev(3, 1'b0, 8'h00);
    ev(3, 1'b1, 8'h01);
    rd(ADDR_ALARM_ONE, 8'h40, 8'hc0);
    ev(2, 1'b0, 8'hff);
    rd(ADDR_ALARM_ONE, 8'h08, 8'h08);
    rnd = $random(seed);
    ev(2, 1'b0, rnd[7:0] & 8'h7f);
    rd(ADDR_ALARM_ONE, 8'h00, 8'h08);
    ev(1, 1'b1, 8'h00);
    rd(ADDR_ALARM_ONE, 8'h02, 8'h02);
    ev(4, 1'b0, 8'h02);
    ev(3, 1'b0, 8'h00);
    rd(ADDR_ALARM_ONE, 8'h03, 8'h03);
    ev(4, 1'b0, 8'h03);
    ev(3, 1'b0, 8'h01);
    rd(ADDR_ALARM_ONE, 8'h02, 8'h03);
    ev(1, 1'b0, 8'h00);
    rnd = $random(seed);
    wr(ADDR_ALARM_ONE, rnd[7:0] | 8'h0a);
    wr(ADDR_SLIP_PHASE_HI, 8'hff);
    rd(ADDR_ALARM_ONE, 8'h00, 8'h0a);
    rd(ADDR_SLIP_PHASE_HI, 8'h40, 8'hd0);
    cyc(1100);
    rd(ADDR_ALARM_ONE, 8'h10, 8'h10);
    line_mode <= 2'h2;
    cyc(4400);
    rd(ADDR_ALARM_ONE, 8'h04, 8'h14);
    wr(ADDR_CTRL, 8'h01);
    rd(ADDR_CTRL, 8'h01, 8'h01);
    line_mode <= 2'h1;
    cyc(4400);
    rd(ADDR_SLIP_PHASE_HI, 8'h20, 8'h20);
    rd(ADDR_ALARM_ONE, 8'h00, 8'h14);
    line_mode <= 2'h0;
    cyc(80);
    rd(ADDR_SLIP_PHASE_HI, 8'h00, 8'h20);
    // Over 989 E-bit errors per second; the earlier remote alarm spoils the first one
    ebit_error <= 1'b1;
    sec(995);
    repeat (4) sec(995);
    rd(ADDR_ALARM_ONE, 8'h00, 8'h20);
    sec(995);
    rd(ADDR_ALARM_ONE, 8'h20, 8'h20);
    sync_lost <= 1'b1;
    sec(995);
    rd(ADDR_ALARM_ONE, 8'h00, 8'h20);
    sync_lost <= 1'b0;
    ebit_error <= 1'b0;
    subbit_tick <= 1'b1;
    sys_fp <= 1'b1;
    cyc(100);
    ext_8k <= 1'b1;
    cyc(8);
    rd(ADDR_PHASE_LO, 8'h60, 8'hf8);
    rd(ADDR_SLIP_PHASE_HI, 8'h00, 8'h0f);
    cyc(2);
    final_report();
  end
endmodule // e1rs_monitor_bench

`default_nettype wire
